/* File: design/spifc_pkg.sv */
//////////////////////////////////////////////////////////////////////////////
// Purpose : types of the serial command port
// Assumes : nothing
// Notes   : shared by the design and the bench
//////////////////////////////////////////////////////////////////////////////
package spifc_pkg;

  // device operating modes
  typedef enum logic [2:0] {
    SPIFC_INIT     = 3'h0,
    SPIFC_NORMAL   = 3'h1,
    SPIFC_STOP     = 3'h2,
    SPIFC_SLEEP    = 3'h3,
    SPIFC_RESTART  = 3'h4,
    SPIFC_FAILSAFE = 3'h5
  } spifc_mode_e;

  // accepted write or status clear
  typedef struct packed {
    logic        valid;
    logic [6:0]  addr;
    logic [15:0] data;
  } spifc_wr_s;

  // mode change request
  typedef struct packed {
    logic        valid;
    spifc_mode_e mode;
  } spifc_mreq_s;

endpackage

/* File: design/spifc_regs.svh */
//////////////////////////////////////////////////////////////////////////////
// Purpose : offsets, field positions, patterns and timing counts of the
//           serial command port
// Assumes : 125 MHz mclk; 7-bit register addresses
// Notes   : definitions only
//////////////////////////////////////////////////////////////////////////////
`ifndef SPIFC_REGS_SVH
`define SPIFC_REGS_SVH

// frame layout (bit 0 travels first)
`define SPIFC_FRAME_BITS   6'h20
`define SPIFC_ADDR_MSB     6
`define SPIFC_WR_BIT       7
`define SPIFC_DATA_LSB     8
`define SPIFC_DATA_MSB     23
`define SPIFC_CK_LSB       24
`define SPIFC_CK_MSB       31
`define SPIFC_RD_AT_BIT    5'h07

// fixed check-field patterns when the checksum is off
`define SPIFC_CK_RX_FIXED  8'hA5
`define SPIFC_CK_TX_FIXED  8'h5A

// checksum: poly, seed, final xor
`define SPIFC_CRC_POLY     8'h2F
`define SPIFC_CRC_INIT     8'hFF
`define SPIFC_CRC_XOR      8'hFF

// control and own status register addresses
`define SPIFC_A_MODE       7'h01
`define SPIFC_A_WDOG       7'h03
`define SPIFC_A_TIMER      7'h08
`define SPIFC_A_HSIDE      7'h0A
`define SPIFC_A_PORT_STAT  7'h43

// mode field of the mode control word
`define SPIFC_MODE_MSB     1
`define SPIFC_MC_NORMAL    2'h0
`define SPIFC_MC_SLEEP     2'h1
`define SPIFC_MC_STOP      2'h2
`define SPIFC_MC_SRESET    2'h3

// timer word: on-time code [7:4], period code [3:0]
`define SPIFC_TMR_ON_LSB   4
`define SPIFC_TMR_PER_MSB  3
// high-side word: sync-input control select
`define SPIFC_HS_SYNC_BIT  8

// port status byte (bits 7:0 of every reply)
`define SPIFC_ST_ERR       0
`define SPIFC_ST_FAIL      7
// own status register payload bits
`define SPIFC_PS_REJECT    0
`define SPIFC_PS_FRAME     1
`define SPIFC_PS_CKFAIL    2

// interrupt pulse low time
`define SPIFC_CLK_MHZ      125
`define SPIFC_INT_LOW_NS   100
`define SPIFC_INT_CYC      ((`SPIFC_INT_LOW_NS * `SPIFC_CLK_MHZ + 999) / 1000)

`endif

/* File: design/spifc_top.sv */
//////////////////////////////////////////////////////////////////////////////
// Purpose : serial command port: 32-bit frame capture, command checks,
//           command-reject and frame-error signalling
// Assumes : select_n, sclk, serial_in, reset_out_n, strap_a are async pins
// Notes   : pins pass two flops; link clock edges found on mclk
//
// Operation
// RULE1: port live in init, normal, stop
// RULE2: full-duplex 32-bit frames
// RULE3: select_n low whole frame
// RULE4: interpret on select rise, release line
// RULE5: sample on falling clock
// RULE6: shift out after rising clock
// RULE7: bad command dropped, sticky reject; a normal-mode sleep request without wake source is still written
// RULE8: stop to sleep: reject, restart
// RULE9: init to stop/sleep: reject, normal
// RULE10: odd watchdog parity rejected
// RULE11: stop accepts few commands
// RULE12: stop with wake events: interrupt
// RULE13: stop to normal: mode only
// RULE14: sleep without wake source: restart
// RULE15: bad timer or sync rejected
// RULE16: stuck frame rejected
// RULE17: unused addresses ignored silently
// RULE18: clock count not 0/32 errors
// RULE19: clock high at select edge errors
// RULE20: clock low at select fall
// RULE21: frame overlapping reset errors
// RULE22: serial_out high in reset
// RULE23: checksum strap: init left anyway; a soft reset mode write in init still keeps init
// RULE24: address, write bit, data fields
// RULE25: restart interprets nothing
// RULE26: fixed check patterns
// RULE27: flags sticky and readable
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/100ps
`include "spifc_regs.svh"

module spifc_top
  import spifc_pkg::*;
(
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        nrst,
  // link pins
  input  wire logic        select_n,
  input  wire logic        sclk,
  input  wire logic        serial_in,
  output logic             serial_out,
  output logic             serial_out_oe,
  // device state
  input  wire logic        reset_out_n,
  input  wire logic        strap_a,
  input  wire spifc_mode_e dev_mode,
  input  wire logic [15:0] mode_reg_cur,
  input  wire logic        wake_src_any,
  input  wire logic        wake_status_any,
  input  wire logic        wake4_sync_pin,
  input  wire logic [5:0]  status_info,
  // register read path
  output logic [6:0]       rd_addr,
  output logic             rd_req,
  input  wire logic [15:0] rd_data,
  // command results
  output spifc_wr_s        wr_out,
  output spifc_mreq_s      mreq_out,
  output logic             command_reject_flag,
  output logic             frame_error_flag,
  output logic             checksum_fail_flag,
  output logic             interrupt_out_n
);

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  ////////////////////////////////////////////////////////////////////////////
  localparam int NSYNC = 5;
  logic [NSYNC-1:0] pin_raw;            // pins in async domain
  logic [NSYNC-1:0] sync1_q;            // first stage, read only by stage two
  logic [NSYNC-1:0] sync2_q;            // safe copies
  logic [NSYNC-1:0] prev_q;             // one cycle older, for edges

  assign pin_raw = {strap_a, reset_out_n, serial_in, sclk, select_n};

  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi++)
    begin : g_sync
      // idle levels at reset keep the port quiet
      always_ff @(posedge mclk or negedge nrst)
      begin
        if (!nrst)
        begin
          sync1_q[gi] <= (gi == 0 || gi == 3) ? 1'b1 : 1'b0;
          sync2_q[gi] <= (gi == 0 || gi == 3) ? 1'b1 : 1'b0;
          prev_q[gi]  <= (gi == 0 || gi == 3) ? 1'b1 : 1'b0;
        end
        else
        begin
          sync1_q[gi] <= pin_raw[gi];
          sync2_q[gi] <= sync1_q[gi];
          prev_q[gi]  <= sync2_q[gi];
        end
      end
    end
  endgenerate

  logic sel_s, sck_s, sdi_s, rsto_s;    // synchronised levels
  logic sel_fall, sel_rise;             // frame start and end
  logic sck_rise, sck_fall;             // link clock edges
  assign sel_s    = sync2_q[0];
  assign sck_s    = sync2_q[1];
  assign sdi_s    = sync2_q[2];
  assign rsto_s   = sync2_q[3];
  assign sel_fall = prev_q[0] & ~sel_s;
  assign sel_rise = ~prev_q[0] & sel_s;
  assign sck_rise = ~prev_q[1] & sck_s & ~sel_s;
  assign sck_fall = prev_q[1] & ~sck_s & ~sel_s;

  ////////////////////////////////////////////////////////////////////////////
  // checksum strap, caught once after reset release
  ////////////////////////////////////////////////////////////////////////////
  logic [1:0] strap_cnt_q;              // waits out the synchroniser
  logic ck_mode_q;                      // checksum mode strapped

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      strap_cnt_q <= 2'h0;
      ck_mode_q   <= 1'b0;
    end
    else if (strap_cnt_q != 2'h3)
    begin
      strap_cnt_q <= strap_cnt_q + 2'h1;
      ck_mode_q   <= sync2_q[4];                                 // RULE23
    end
  end

  // checksum over frame bits 23..0, bit 23 first
  function automatic logic [7:0] crc8(input logic [23:0] d);
    logic [7:0] c;
    c = `SPIFC_CRC_INIT;
    for (int i = 23; i >= 0; i--)
    begin
      c = (c[7] ^ d[i]) ? ((c << 1) ^ `SPIFC_CRC_POLY) : (c << 1);
    end
    return c ^ `SPIFC_CRC_XOR;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // receive side: shift and clock count
  ////////////////////////////////////////////////////////////////////////////
  logic [31:0] rx_q;                    // received word, bit 0 first in
  logic [5:0]  cnt_q;                   // falling edges seen, saturates
  logic        hi_at_fall_q;            // clock high when select fell
  logic        rst_seen_q;              // reset_out_n low during frame
  logic        port_on;                 // mode lets the port drive

  assign port_on = (dev_mode != SPIFC_SLEEP) && (dev_mode != SPIFC_FAILSAFE);

  // capture on each falling clock, lsb first
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      rx_q  <= 32'h0000_0000;
      cnt_q <= 6'h00;
    end
    else if (sel_fall)
    begin
      cnt_q <= 6'h00;
    end
    else if (sck_fall)
    begin
      rx_q <= {sdi_s, rx_q[31:1]};                               // RULE5
      if (cnt_q <= `SPIFC_FRAME_BITS)
      begin
        cnt_q <= cnt_q + 6'h01;
      end
    end
  end

  // edge faults of the current frame
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      hi_at_fall_q <= 1'b0;
      rst_seen_q   <= 1'b0;
    end
    else if (sel_fall)
    begin
      hi_at_fall_q <= sck_s;                                     // RULE19
      rst_seen_q   <= ~rsto_s;                                   // RULE21
    end
    else if (!sel_s && !rsto_s)
    begin
      rst_seen_q <= 1'b1;                                        // RULE21
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // frame verdict, taken on the select rise
  ////////////////////////////////////////////////////////////////////////////
  logic        err_now;                 // framing fault this frame
  logic        fr_ok;                   // 32 clean clocks
  logic        live;                    // mode allows interpretation
  logic [6:0]  addr;
  logic [15:0] data;
  logic        ck_bad, stuck, addr_ok, is_stat;
  logic        rej, ckf, wr_ok, mv, clr_own, int_trig;
  spifc_mode_e mm;

  assign err_now = sel_rise && ((cnt_q != 6'h00 && cnt_q != `SPIFC_FRAME_BITS) // RULE18
                   || sck_s || hi_at_fall_q || rst_seen_q || !rsto_s);      // RULE19
  assign fr_ok   = sel_rise && !err_now && cnt_q == `SPIFC_FRAME_BITS;
  assign live    = dev_mode == SPIFC_INIT || dev_mode == SPIFC_NORMAL
                   || dev_mode == SPIFC_STOP;                    // RULE1 RULE25
  assign addr    = rx_q[`SPIFC_ADDR_MSB:0];                      // RULE24
  assign data    = rx_q[`SPIFC_DATA_MSB:`SPIFC_DATA_LSB];
  assign stuck   = rx_q == 32'h0000_0000 || rx_q == 32'hFFFF_FFFF;
  assign ck_bad  = ck_mode_q ? (crc8(rx_q[23:0]) != rx_q[`SPIFC_CK_MSB:`SPIFC_CK_LSB])
                   : (rx_q[`SPIFC_CK_MSB:`SPIFC_CK_LSB] != `SPIFC_CK_RX_FIXED); // RULE26
  assign is_stat = addr[6];
  // populated control and status banks
  assign addr_ok = (addr >= 7'h01 && addr <= 7'h0B) || (addr >= 7'h10 && addr <= 7'h1D)
                   || (addr >= 7'h30 && addr <= 7'h46) || (addr >= 7'h50 && addr <= 7'h5B)
                   || (addr >= 7'h60 && addr <= 7'h63) || addr == 7'h70;

  // a reject drops the write, except a sleep request without wake source in normal mode
  always_comb
  begin
    rej      = 1'b0;
    ckf      = 1'b0;
    wr_ok    = 1'b0;
    mv       = 1'b0;
    mm       = SPIFC_NORMAL;
    clr_own  = 1'b0;
    int_trig = 1'b0;
    if (fr_ok && live)                                           // RULE4
    begin
      // strapped: init left, unless a mode write carries the soft reset code
      if (ck_mode_q && dev_mode == SPIFC_INIT)
      begin
        mv = 1'b1;                                               // RULE23
      end
      if (stuck)
      begin
        rej = 1'b1;                                              // RULE16
      end
      else if (ck_bad)
      begin
        ckf = 1'b1;                                              // RULE23
      end
      else if (!rx_q[`SPIFC_WR_BIT] || !addr_ok)
      begin
        // read-only or unused: ignore                           // RULE17
      end
      else if (is_stat)
      begin
        wr_ok   = 1'b1;
        clr_own = addr == `SPIFC_A_PORT_STAT;                    // RULE27
      end
      else if (dev_mode == SPIFC_STOP && addr != `SPIFC_A_MODE
               && addr != `SPIFC_A_WDOG)
      begin
        rej = 1'b1;                                              // RULE11
      end
      else if (addr == `SPIFC_A_WDOG && ^data)
      begin
        rej = 1'b1;                                              // RULE10
      end
      else if (addr == `SPIFC_A_TIMER && data[7:4] >= data[3:0])
      begin
        rej = 1'b1;                                              // RULE15
      end
      else if (addr == `SPIFC_A_HSIDE && data[`SPIFC_HS_SYNC_BIT - 8]
               && !wake4_sync_pin)
      begin
        rej = 1'b1;                                              // RULE15
      end
      else if (addr == `SPIFC_A_MODE)
      begin
        case (dev_mode)
          SPIFC_INIT:
          begin
            if (data[1:0] == `SPIFC_MC_SLEEP || data[1:0] == `SPIFC_MC_STOP)
            begin
              rej = 1'b1;                                        // RULE9
              mv  = 1'b1;
            end
            else
            begin
              wr_ok = 1'b1;
              mv    = data[1:0] == `SPIFC_MC_NORMAL;
            end
          end
          SPIFC_STOP:
          begin
            if (data[1:0] == `SPIFC_MC_SLEEP)
            begin
              rej = 1'b1;                                        // RULE8
              mv  = 1'b1;
              mm  = SPIFC_RESTART;
            end
            else if (data[1:0] == `SPIFC_MC_NORMAL)
            begin
              mv    = 1'b1;                                      // RULE13
              rej   = data[15:2] != mode_reg_cur[15:2];
              wr_ok = !rej;
            end
            else if (data[1:0] == `SPIFC_MC_SRESET)
            begin
              wr_ok = 1'b1;                                      // RULE11
            end
            else
            begin
              rej = data != mode_reg_cur;                        // RULE11
            end
          end
          default:
          begin
            // normal mode
            wr_ok = 1'b1;
            if (data[1:0] == `SPIFC_MC_SLEEP)
            begin
              mv  = 1'b1;
              mm  = wake_src_any ? SPIFC_SLEEP : SPIFC_RESTART;  // RULE14
              rej = !wake_src_any;
            end
            else if (data[1:0] == `SPIFC_MC_STOP)
            begin
              mv       = 1'b1;
              mm       = SPIFC_STOP;
              int_trig = wake_status_any;                        // RULE12
            end
          end
        endcase
      end
      else
      begin
        wr_ok = 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // results and sticky flags
  ////////////////////////////////////////////////////////////////////////////
  logic [$clog2(`SPIFC_INT_CYC + 1)-1:0] int_cnt_q;  // interrupt low time

  // one-cycle write and mode strobes
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      wr_out   <= '0;
      mreq_out <= '0;
    end
    else
    begin
      wr_out.valid   <= wr_ok;                                   // RULE7
      wr_out.addr    <= addr;
      wr_out.data    <= data;
      mreq_out.valid <= mv;
      mreq_out.mode  <= mm;
    end
  end

  // set wins over clear in the same cycle
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      command_reject_flag <= 1'b0;
      frame_error_flag    <= 1'b0;
      checksum_fail_flag  <= 1'b0;
    end
    else
    begin
      command_reject_flag <= (command_reject_flag & ~clr_own) | rej; // RULE7 RULE27
      frame_error_flag    <= (frame_error_flag & ~clr_own) | err_now; // RULE18 RULE27
      checksum_fail_flag  <= (checksum_fail_flag & ~clr_own) | ckf;
    end
  end

  // low pulse on stop entry with pending wake events
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      int_cnt_q       <= '0;
      interrupt_out_n <= 1'b1;
    end
    else
    begin
      if (int_trig)
      begin
        int_cnt_q <= ($clog2(`SPIFC_INT_CYC + 1))'(`SPIFC_INT_CYC); // RULE12
      end
      else if (int_cnt_q != '0)
      begin
        int_cnt_q <= int_cnt_q - 1'b1;
      end
      interrupt_out_n <= !(int_trig || int_cnt_q > 1);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // transmit side
  ////////////////////////////////////////////////////////////////////////////
  logic [23:0] tx_q;                    // status byte and read data
  logic [4:0]  idx_q;                   // bit now on serial_out
  logic [31:0] tx_word;                 // full reply with check field
  logic        rd_hit_q;                // read data arrives next cycle
  logic [7:0]  st_byte;

  assign tx_word = {ck_mode_q ? crc8(tx_q) : `SPIFC_CK_TX_FIXED, tx_q}; // RULE26
  // error bit leads the reply, so it is seen before any clock
  assign st_byte = {command_reject_flag | checksum_fail_flag, status_info,
                    frame_error_flag};                           // RULE19 RULE27

  // address complete after seven bits
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      rd_addr  <= 7'h00;
      rd_req   <= 1'b0;
      rd_hit_q <= 1'b0;
    end
    else
    begin
      rd_req   <= sck_fall && cnt_q == 6'h06;
      rd_hit_q <= rd_req;
      if (sck_fall && cnt_q == 6'h06)
      begin
        rd_addr <= {sdi_s, rx_q[31:26]};
      end
    end
  end

  // reply loaded at select fall, data patched later
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      tx_q <= 24'h00_0000;
    end
    else if (sel_fall)
    begin
      tx_q <= {16'h0000, st_byte};
    end
    else if (rd_hit_q)
    begin
      // own status comes from the flags
      tx_q[23:8] <= (rd_addr == `SPIFC_A_PORT_STAT) ?
                    {13'h0000, checksum_fail_flag, frame_error_flag,
                     command_reject_flag} : rd_data;
    end
  end

  // one bit per rising clock; held high while reset_out_n low
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      idx_q         <= 5'h00;
      serial_out    <= 1'b1;
      serial_out_oe <= 1'b0;
    end
    else
    begin
      serial_out_oe <= !sel_s && port_on;                        // RULE4 RULE2
      if (sel_fall)
      begin
        idx_q      <= 5'h00;
        serial_out <= !rsto_s | frame_error_flag;                // RULE19 RULE22
      end
      else if (!rsto_s)
      begin
        serial_out <= 1'b1;                                      // RULE22
      end
      else if (sck_rise)
      begin
        idx_q      <= idx_q + 5'h01;
        serial_out <= tx_word[idx_q + 5'h01];                    // RULE6
      end
    end
  end

endmodule // spifc_top

/* File: verif/spifc_asserts.sv */
// Purpose : port-level checks of the serial command port
// Assumes : mclk domain only; nrst async active low
// Notes   : bind at the foot
`timescale 1ns/100ps
module spifc_chk
  import spifc_pkg::*;
(
  // clock and reset
  input wire logic        mclk,
  input wire logic        nrst,
  // watched pins and results
  input wire logic        select_n,
  input wire logic        reset_out_n,
  input wire spifc_mode_e dev_mode,
  input wire logic        serial_out,
  input wire logic        serial_out_oe,
  input wire logic        rd_req,
  input wire spifc_wr_s   wr_out,
  input wire spifc_mreq_s mreq_out,
  input wire logic        command_reject_flag,
  input wire logic        frame_error_flag,
  input wire logic        interrupt_out_n
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);
  // interrupt low time, longer than a glitch
  sequence s_int_low;
    !interrupt_out_n [*8];
  endsequence
  property p_int; $fell(interrupt_out_n) |-> s_int_low; endproperty
  property p_rst_hi; !reset_out_n [*5] |-> serial_out; endproperty
  property p_release; select_n [*6] |-> !serial_out_oe; endproperty
  property p_off;
    (dev_mode == SPIFC_SLEEP || dev_mode == SPIFC_FAILSAFE) |=> !serial_out_oe;
  endproperty
  // a clear through the own status register is the only way down
  property p_rej_keep;
    command_reject_flag |=> command_reject_flag || (wr_out.valid && wr_out.addr == 7'h43);
  endproperty
  property p_fe_keep;
    frame_error_flag |=> frame_error_flag || (wr_out.valid && wr_out.addr == 7'h43);
  endproperty
  // verdicts only once select has been high a while
  property p_verdict;
    ($rose(command_reject_flag) || $rose(frame_error_flag)) |-> select_n && $past(select_n, 2);
  endproperty
  property p_wr_pulse; wr_out.valid |=> !wr_out.valid; endproperty
  property p_mreq_end; mreq_out.valid |-> select_n; endproperty
  property p_rd_pulse; rd_req |=> !rd_req; endproperty
  a_int: assert property (p_int) else $error("short interrupt");
  a_rst_hi: assert property (p_rst_hi) else $error("out low in reset");
  a_release: assert property (p_release) else $error("not released");
  a_off: assert property (p_off) else $error("driven while off");
  a_rej_keep: assert property (p_rej_keep) else $error("reject dropped");
  a_fe_keep: assert property (p_fe_keep) else $error("error dropped");
  a_verdict: assert property (p_verdict) else $error("flag mid frame");
  a_wr_pulse: assert property (p_wr_pulse) else $error("long write");
  a_mreq_end: assert property (p_mreq_end) else $error("mode mid frame");
  a_rd_pulse: assert property (p_rd_pulse) else $error("long read");
  c_int: cover property ($fell(interrupt_out_n));
endmodule // spifc_chk

bind spifc_top spifc_chk i_spifc_chk (.*);

/* File: verif/spifc_ctrl_model.sv */
// Purpose : bus controller driving frames at the link pins
// Assumes : 80 ns link clock
// Notes   : serial_in toggles while idle to expose stale bits
`timescale 1ns/100ps
module spifc_ctrl_model (
  // timing reference
  input wire logic mclk,
  // link pins
  output logic     select_n,
  output logic     sclk,
  output logic     serial_in,
  input wire logic serial_out
);
  initial begin select_n = 1'b1; sclk = 1'b0; serial_in = 1'b0; end
  task automatic tick(input int k);
    repeat (k) @(posedge mclk);
    #1;
  endtask
  // n clocks; hi holds sclk high at select edges
  task automatic xfer(input logic [31:0] d, input int n, input bit hi, output logic [31:0] q);
    q = '0;
    tick(1);
    sclk = hi;
    select_n = 1'b0;
    tick(10);
    q[0] = serial_out;
    for (int i = 0; i < n; i++)
    begin
      q[i % 32] = serial_out;
      serial_in = d[i % 32];
      sclk = 1'b1;
      tick(5);
      sclk = 1'b0;
      tick(5);
    end
    sclk = hi;
    tick(2);
    select_n = 1'b1;
    tick(2);
    sclk = 1'b0;
    serial_in = ~serial_in;
    tick(6);
  endtask
endmodule // spifc_ctrl_model

/* File: verif/spifc_top_test.sv */
// Purpose : self-checking bench of the serial command port
// Assumes : checksum strap off, so check fields are fixed patterns
// Notes   : verdicts read 18 cycles after each select rise
`timescale 1ns/100ps
`define CHK_EQ(n, e, g) begin samples_checked++; if ((g) !== (e)) begin n_errors++; \
  $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module spifc_top_test;
  import spifc_pkg::*;
  logic mclk = 1'b0, nrst = 1'b0, reset_out_n = 1'b1, strap_a = 1'b0;
  logic select_n, sclk, serial_in, serial_out, serial_out_oe, rd_req;
  logic wake_src_any = 1'b1, wake_status_any = 1'b0, wake4_sync_pin = 1'b0;
  logic command_reject_flag, frame_error_flag, checksum_fail_flag, interrupt_out_n;
  logic [15:0] mode_reg_cur = 16'h0000, rd_data;
  logic [6:0] rd_addr;
  logic [5:0] status_info = 6'h2D;
  logic [31:0] q;
  spifc_mode_e dev_mode = SPIFC_NORMAL;
  spifc_wr_s wr_out, wr_seen;
  spifc_mreq_s mreq_out, mr_seen;
  int n_errors = 0, samples_checked = 0;
  always #4 mclk = ~mclk;
  // far-side register file answers with an address-derived word
  assign rd_data = {9'h000, rd_addr} ^ 16'hC300;
  always @(posedge mclk)
  begin
    if (wr_out.valid === 1'b1) wr_seen <= wr_out;
    if (mreq_out.valid === 1'b1) mr_seen <= mreq_out;
  end
  spifc_top i_spifc_top (.*);
  spifc_ctrl_model i_spifc_ctrl_model (.*);
  //////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] mk(input logic [6:0] a, input logic [15:0] d);
    return {8'hA5, d, 1'b1, a};
  endfunction
  task automatic run(input logic [31:0] w, input int n, input bit hi);
    wr_seen = '0;
    mr_seen = '0;
    i_spifc_ctrl_model.xfer(w, n, hi, q);
    i_spifc_ctrl_model.tick(10);
  endtask
  // clear through the own status register, then expect both flags down
  task automatic clr;
    dev_mode = SPIFC_NORMAL;
    run(mk(7'h43, 16'h0007), 32, 1'b0);
    `CHK_EQ("reject cleared", 1'b0, command_reject_flag)
    `CHK_EQ("frame err cleared", 1'b0, frame_error_flag)
  endtask
  task automatic cmd(input spifc_mode_e m, input logic [31:0] w, input logic rj, input logic wv,
                     input logic mv, input spifc_mode_e mm);
    dev_mode = m;
    run(w, 32, 1'b0);
    `CHK_EQ("reject", rj, command_reject_flag)
    `CHK_EQ("write", wv, wr_seen.valid)
    `CHK_EQ("mreq", mv, mr_seen.valid)
    if (wv) `CHK_EQ("wr word", {w[6:0], w[23:8]}, {wr_seen.addr, wr_seen.data})
    if (mv) `CHK_EQ("mreq mode", mm, mr_seen.mode)
    clr();
  endtask
  task automatic t_read;
    run({8'hA5, 16'h0000, 1'b0, 7'h05}, 32, 1'b0);
    `CHK_EQ("reply", {8'h5A, 16'hC305, 1'b0, 6'h2D, 1'b0}, q)
    `CHK_EQ("read no write", 1'b0, wr_seen.valid)
  endtask
  task automatic t_cmds;
    cmd(SPIFC_NORMAL, mk(7'h05, 16'h1234), 0, 1, 0, SPIFC_NORMAL);
    cmd(SPIFC_NORMAL, mk(7'h0C, 16'h1234), 0, 0, 0, SPIFC_NORMAL);
    cmd(SPIFC_INIT, mk(7'h01, 16'h0002), 1, 0, 1, SPIFC_NORMAL);
    cmd(SPIFC_INIT, mk(7'h01, 16'h0001), 1, 0, 1, SPIFC_NORMAL);
    cmd(SPIFC_STOP, mk(7'h01, 16'h0001), 1, 0, 1, SPIFC_RESTART);
    cmd(SPIFC_STOP, mk(7'h05, 16'h1111), 1, 0, 0, SPIFC_NORMAL);
    cmd(SPIFC_STOP, mk(7'h01, 16'h0004), 1, 0, 1, SPIFC_NORMAL);
    cmd(SPIFC_NORMAL, mk(7'h03, 16'h0001), 1, 0, 0, SPIFC_NORMAL);
    cmd(SPIFC_NORMAL, mk(7'h08, 16'h0033), 1, 0, 0, SPIFC_NORMAL);
    cmd(SPIFC_NORMAL, mk(7'h0A, 16'h0001), 1, 0, 0, SPIFC_NORMAL);
    cmd(SPIFC_NORMAL, 32'h00000000, 1, 0, 0, SPIFC_NORMAL);
    cmd(SPIFC_NORMAL, 32'hFFFFFFFF, 1, 0, 0, SPIFC_NORMAL);
    cmd(SPIFC_RESTART, mk(7'h05, 16'h1234), 0, 0, 0, SPIFC_NORMAL);
    cmd(SPIFC_SLEEP, mk(7'h05, 16'h1234), 0, 0, 0, SPIFC_NORMAL);
    wake_src_any = 1'b0;
    cmd(SPIFC_NORMAL, mk(7'h01, 16'h0001), 1, 1, 1, SPIFC_RESTART);
    wake_src_any = 1'b1;
    run({8'h00, 16'h1234, 1'b1, 7'h05}, 32, 1'b0);
    `CHK_EQ("bad check", 3'b100, {checksum_fail_flag, command_reject_flag, wr_seen.valid})
    clr();
  endtask
  task automatic t_int;
    int k;
    wake_status_any = 1'b1;
    wr_seen = '0;
    i_spifc_ctrl_model.xfer(mk(7'h01, 16'h0002), 32, 1'b0, q);
    for (k = 0; k < 30 && interrupt_out_n !== 1'b0; k++) i_spifc_ctrl_model.tick(1);
    `CHK_EQ("interrupt", 1'b0, interrupt_out_n)
    `CHK_EQ("no reject", 1'b0, command_reject_flag)
    wake_status_any = 1'b0;
    i_spifc_ctrl_model.tick(20);
  endtask
  task automatic t_ferr;
    run(mk(7'h05, 16'h1234), 31, 1'b0);
    `CHK_EQ("short frame err", 1'b1, frame_error_flag)
    `CHK_EQ("short discarded", 1'b0, wr_seen.valid)
    run(32'h0, 0, 1'b0);
    `CHK_EQ("err on first bit", 1'b1, q[0])
    clr();
    run(32'h0, 0, 1'b0);
    `CHK_EQ("zero clocks ok", 1'b0, frame_error_flag)
    run(mk(7'h05, 16'h1234), 32, 1'b1);
    `CHK_EQ("clock high at edge", 1'b1, frame_error_flag)
    clr();
    reset_out_n = 1'b0;
    run(mk(7'h05, 16'h1234), 32, 1'b0);
    `CHK_EQ("out high in reset", 32'hFFFFFFFF, q)
    reset_out_n = 1'b1;
    i_spifc_ctrl_model.tick(4);
    `CHK_EQ("reset overlap err", 1'b1, frame_error_flag)
    clr();
  endtask
  task automatic print_verdict;
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial
  begin
    repeat (5) @(posedge mclk);
    #1 nrst = 1'b1;
    i_spifc_ctrl_model.tick(5);
    `CHK_EQ("reset out", 1'b1, serial_out)
    `CHK_EQ("reset oe", 1'b0, serial_out_oe)
    `CHK_EQ("reset flags", 2'b00, {command_reject_flag, frame_error_flag})
    t_read();
    t_cmds();
    t_int();
    t_ferr();
    print_verdict();
  end
endmodule // spifc_top_test
